// File: common/pief_pkg.sv
// Shared constants, types and the register map of the port isolation egress filter.
package pief_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  localparam int NPORT = 11;
  localparam int PW = 4;
  localparam logic [3:0] LAST_PORT = 4'ha;
  localparam logic [3:0] MGMT_PORT = 4'h0;

  typedef logic [NPORT-1:0] pief_mask_t;

  localparam pief_mask_t ROW_RST = 11'h7ff;
  localparam pief_mask_t STAGE_RST = 11'h7ff;
  localparam logic [3:0] RANGE_LO_RST = 4'h0;
  localparam logic [3:0] RANGE_HI_RST = 4'ha;

  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] OFS_STAGE = 8'h00;
  localparam logic [7:0] OFS_RANGE = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [1:0] OFS_ROW_PAGE = 2'h1;
  localparam int RANGE_LO_LSB = 0;
  localparam int RANGE_HI_LSB = 8;
  localparam int CMD_OP_LSB = 0;

  typedef enum logic [1:0] {
    PIEF_OP_IDLE,
    PIEF_OP_LOAD,
    PIEF_OP_SET_ALL,
    PIEF_OP_CLR_ALL
  } pief_op_e;

  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic valid;
    logic [PW-1:0] src;
    pief_mask_t dst;
  } pief_fwd_s;

  typedef struct packed {
    pief_mask_t [NPORT-1:0] row;
    pief_mask_t stage;
    logic [3:0] lo;
    logic [3:0] hi;
    logic ack;
    logic [31:0] rdat;
  } pief_state_s;

  // Byte lane 0 carries bits 7:0 of a mask and lane 1 the upper bits.
  function automatic pief_mask_t merge_mask(pief_mask_t old, logic [15:0] dat, logic [1:0] sel);
    pief_mask_t m;
    m = old;
    if (sel[0]) begin
      m[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      m[NPORT-1:8] = dat[NPORT-1:8];
    end
    return m;
  endfunction

endpackage

// File: rtl/pief_range_dec.sv
// Decoder that turns a receiving port range into one enable bit per port.
`timescale 1ns/1ns
module pief_range_dec #(
  parameter int NPORT = pief_pkg::NPORT
) (
  input wire logic [3:0] lo,
  input wire logic [3:0] hi,
  output logic [NPORT-1:0] en
);

  ////////////////////////////////////////////////////////////////////////////////
  // An inverted range selects nothing, so a bad setting cannot touch any row.
  for (genvar i = 0; i < NPORT; i++) begin : g_port
    localparam logic [3:0] IDX = 4'(i);
    assign en[i] = (IDX >= lo) && (IDX <= hi); // R7
  end

endmodule

// File: rtl/pief_filter.sv
// Forwarding stage that cuts a destination set down to the source port's egress mask.
`timescale 1ns/1ns
module pief_filter (
  input wire logic mclk,
  input wire logic resetn,
  input wire pief_pkg::pief_fwd_s req,
  input wire pief_pkg::pief_mask_t [pief_pkg::NPORT-1:0] rows,
  output pief_pkg::pief_fwd_s resp
);

  pief_pkg::pief_fwd_s s_q;
  pief_pkg::pief_fwd_s s_d;
  pief_pkg::pief_mask_t row_sel;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    row_sel = '0;
    if (req.src <= pief_pkg::LAST_PORT) begin
      row_sel = rows[req.src]; // R1
    end
    s_d = s_q;
    s_d.valid = req.valid;
    s_d.src = req.src;
    // The tag of the frame never reaches this stage; only the source row limits it.
    s_d.dst = req.dst & row_sel; // R1 R2 R3
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign resp = s_q;

  ////////////////////////////////////////////////////////////////////////////////
  property p_fwd_subset;
    @(posedge mclk) disable iff (!resetn)
    req.valid |=> resp.valid && (resp.dst == ($past(req.dst) & $past(row_sel)));
  endproperty
  a_fwd_subset: assert property (p_fwd_subset) else $error("forwarded set exceeds egress mask"); // R1

  property p_same_in_same_out;
    @(posedge mclk) disable iff (!resetn)
    (req.valid && $stable(req) && $stable(rows)) |=> $stable(resp.dst);
  endproperty
  a_same_in_same_out: assert property (p_same_in_same_out) else $error("decision varied for same port"); // R2

  property p_mgmt_block;
    @(posedge mclk) disable iff (!resetn)
    (req.valid && !row_sel[pief_pkg::MGMT_PORT]) |=> !resp.dst[pief_pkg::MGMT_PORT];
  endproperty
  a_mgmt_block: assert property (p_mgmt_block) else $error("management port reached while blocked"); // R3

  property p_idle_quiet;
    @(posedge mclk) disable iff (!resetn)
    !req.valid |=> !resp.valid;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("answer without a request"); // R1

  property p_bad_src;
    @(posedge mclk) disable iff (!resetn)
    (req.valid && (req.src > pief_pkg::LAST_PORT)) |=> (resp.dst == '0);
  endproperty
  a_bad_src: assert property (p_bad_src) else $error("unknown source port forwarded"); // R1

endmodule

// File: rtl/pief_top.sv
// Port isolation egress filter: per-port egress masks behind a Wishbone slave.
//
// The placing of the registers and the Wishbone slave port were decided locally.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Operation
// R1: Each receiving port has its own egress mask; other destinations are dropped.
// R2: VLAN tags never influence the decision; only the source mask does.
// R3: Port 0 is management; without its bit, that port cannot reach it.
// R4: Masks are one-way; the reverse direction is never implied.
// R5: After reset every pair is allowed, including to and from port 0.
// R6: Commands exist to enable all and to disable all egress bits.
// R7: One command applies a mask to a whole port range, port 0 included.
// R8: Readback shows the allowed or blocked state of every port pair.
// R9: Every egress bit of every row, ports 0 to 10, is writable alone.
// R10: Mask updates land in one edge; no decision sees a half-written mask.
module pief_top (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire pief_pkg::pief_fwd_s fwd_req,
  output pief_pkg::pief_fwd_s fwd_resp
);

  pief_pkg::pief_state_s s_q;
  pief_pkg::pief_state_s s_d;
  logic take;
  logic wr;
  logic rd;
  logic [3:0] row_idx;
  logic row_hit;
  logic [pief_pkg::NPORT-1:0] range_en;
  pief_pkg::pief_op_e op;
  logic seen_q;

  ////////////////////////////////////////////////////////////////////////////////
  // A request is taken once; the registered ack blocks a second take of it.
  assign take = wb_cyc_i && wb_stb_i && !s_q.ack;
  assign wr = take && wb_we_i;
  assign rd = take && !wb_we_i;
  assign row_idx = wb_adr_i[5:2];
  assign row_hit = (wb_adr_i[7:6] == pief_pkg::OFS_ROW_PAGE) && (wb_adr_i[1:0] == 2'h0)
    && (row_idx <= pief_pkg::LAST_PORT);
  assign op = pief_pkg::pief_op_e'(wb_dat_i[pief_pkg::CMD_OP_LSB +: 2]);

  pief_range_dec #(
    .NPORT(pief_pkg::NPORT)
  ) u_range (
    .lo(s_q.lo),
    .hi(s_q.hi),
    .en(range_en)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.ack = take;
    s_d.rdat = '0;
    if (wr) begin
      if (wb_adr_i == pief_pkg::OFS_STAGE) begin
        s_d.stage = pief_pkg::merge_mask(s_q.stage, wb_dat_i[15:0], wb_sel_i[1:0]);
      end else if (wb_adr_i == pief_pkg::OFS_RANGE) begin
        if (wb_sel_i[0]) begin
          s_d.lo = wb_dat_i[pief_pkg::RANGE_LO_LSB +: 4];
        end
        if (wb_sel_i[1]) begin
          s_d.hi = wb_dat_i[pief_pkg::RANGE_HI_LSB +: 4];
        end
      end else if ((wb_adr_i == pief_pkg::OFS_CMD) && wb_sel_i[0]) begin
        for (int i = 0; i < pief_pkg::NPORT; i++) begin
          if (range_en[i]) begin // R7
            unique case (op)
              pief_pkg::PIEF_OP_IDLE: s_d.row[i] = s_q.row[i];
              pief_pkg::PIEF_OP_LOAD: s_d.row[i] = s_q.stage; // R7
              pief_pkg::PIEF_OP_SET_ALL: s_d.row[i] = '1; // R6
              pief_pkg::PIEF_OP_CLR_ALL: s_d.row[i] = '0; // R6
            endcase
          end
        end
      end else if (row_hit) begin
        // Only the addressed row changes; the mirror row is left alone.
        s_d.row[row_idx] = pief_pkg::merge_mask(s_q.row[row_idx], wb_dat_i[15:0], wb_sel_i[1:0]); // R4 R9
      end
    end else if (rd) begin
      if (wb_adr_i == pief_pkg::OFS_STAGE) begin
        s_d.rdat[pief_pkg::NPORT-1:0] = s_q.stage;
      end else if (wb_adr_i == pief_pkg::OFS_RANGE) begin
        s_d.rdat[pief_pkg::RANGE_LO_LSB +: 4] = s_q.lo;
        s_d.rdat[pief_pkg::RANGE_HI_LSB +: 4] = s_q.hi;
      end else if (row_hit) begin
        s_d.rdat[pief_pkg::NPORT-1:0] = s_q.row[row_idx]; // R8
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < pief_pkg::NPORT; i++) begin
        s_q.row[i] <= pief_pkg::ROW_RST; // R5
      end
      s_q.stage <= pief_pkg::STAGE_RST;
      s_q.lo <= pief_pkg::RANGE_LO_RST;
      s_q.hi <= pief_pkg::RANGE_HI_RST;
      s_q.ack <= 1'b0;
      s_q.rdat <= '0;
    end else begin
      s_q <= s_d; // R10
    end
  end

  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdat;

  ////////////////////////////////////////////////////////////////////////////////
  // The filter reads the registered matrix, so a command is seen whole or not at all.
  pief_filter u_filter (
    .mclk(mclk),
    .resetn(resetn),
    .req(fwd_req),
    .rows(s_q.row), // R10
    .resp(fwd_resp)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  property p_reset_all_allowed;
    @(posedge mclk) disable iff (!resetn)
    !seen_q |-> (s_q.row == {pief_pkg::NPORT{pief_pkg::ROW_RST}});
  endproperty
  a_reset_all_allowed: assert property (p_reset_all_allowed) else $error("matrix not all allowed after reset"); // R5

  property p_ack_once;
    @(posedge mclk) disable iff (!resetn)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("bus ack not a single cycle after request");

  property p_set_all;
    @(posedge mclk) disable iff (!resetn)
    (wr && (wb_adr_i == pief_pkg::OFS_CMD) && wb_sel_i[0] && (op == pief_pkg::PIEF_OP_SET_ALL)
      && range_en[0]) |=> (s_q.row[0] == '1);
  endproperty
  a_set_all: assert property (p_set_all) else $error("enable all left a bit clear"); // R6

  property p_clr_all;
    @(posedge mclk) disable iff (!resetn)
    (wr && (wb_adr_i == pief_pkg::OFS_CMD) && wb_sel_i[0] && (op == pief_pkg::PIEF_OP_CLR_ALL)
      && range_en[pief_pkg::NPORT-1]) |=> (s_q.row[pief_pkg::NPORT-1] == '0);
  endproperty
  a_clr_all: assert property (p_clr_all) else $error("disable all left a bit set"); // R6

  property p_range_outside;
    @(posedge mclk) disable iff (!resetn)
    (wr && (wb_adr_i == pief_pkg::OFS_CMD) && !range_en[pief_pkg::NPORT-1])
      |=> $stable(s_q.row[pief_pkg::NPORT-1]);
  endproperty
  a_range_outside: assert property (p_range_outside) else $error("row outside range was changed"); // R7

  property p_range_load;
    @(posedge mclk) disable iff (!resetn)
    (wr && (wb_adr_i == pief_pkg::OFS_CMD) && wb_sel_i[0] && (op == pief_pkg::PIEF_OP_LOAD) && range_en[0])
      |=> (s_q.row[0] == $past(s_q.stage));
  endproperty
  a_range_load: assert property (p_range_load) else $error("range load missed the staged mask"); // R7

  property p_readback;
    @(posedge mclk) disable iff (!resetn)
    (rd && row_hit) |=> wb_ack_o && (wb_dat_o[pief_pkg::NPORT-1:0] == $past(s_q.row[row_idx]))
      && (wb_dat_o[31:pief_pkg::NPORT] == '0);
  endproperty
  a_readback: assert property (p_readback) else $error("row readback differs from the mask"); // R8

  property p_bit_write;
    @(posedge mclk) disable iff (!resetn)
    (wr && row_hit && (wb_sel_i[1:0] == 2'h3))
      |=> (s_q.row[$past(row_idx)] == $past(wb_dat_i[pief_pkg::NPORT-1:0]));
  endproperty
  a_bit_write: assert property (p_bit_write) else $error("direct row write not stored"); // R9

  property p_one_way;
    @(posedge mclk) disable iff (!resetn)
    (wr && row_hit && (row_idx != 4'h0)) |=> $stable(s_q.row[0]);
  endproperty
  a_one_way: assert property (p_one_way) else $error("write to one row altered another"); // R4

  property p_atomic;
    @(posedge mclk) disable iff (!resetn)
    !wr |=> $stable(s_q.row);
  endproperty
  a_atomic: assert property (p_atomic) else $error("mask changed without a bus write"); // R10

  property p_dat_quiet;
    @(posedge mclk) disable iff (!resetn)
    !wb_ack_o |-> (wb_dat_o == '0);
  endproperty
  a_dat_quiet: assert property (p_dat_quiet) else $error("read data outside the ack cycle"); // R8

endmodule

// File: bench/pief_fwd_model.sv
// Forwarding engine model that presents destination sets and captures the filtered answers.
`timescale 1ns/1ns
module pief_fwd_model (
  input wire logic mclk,
  output pief_pkg::pief_fwd_s fwd_req,
  input wire pief_pkg::pief_fwd_s fwd_resp
);
  initial begin
    fwd_req = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // A released request shows the inverse pattern, so a stale value is never mistaken for a fresh one.
  // The request stands for two edges, so the same packet is decided twice against an unchanged matrix.
  task automatic send(input logic [3:0] s, input pief_pkg::pief_mask_t d, output pief_pkg::pief_fwd_s r);
    @(posedge mclk);
    fwd_req <= '{valid: 1'b1, src: s, dst: d};
    @(posedge mclk);
    @(posedge mclk);
    fwd_req <= '{valid: 1'b0, src: ~s, dst: ~d};
    @(negedge mclk);
    r = fwd_resp;
  endtask
endmodule

// File: bench/testbench.sv
// Self-checking bench for the port isolation egress filter.
`timescale 1ns/1ns
module testbench;
  logic mclk;
  logic resetn;
  logic wb_cyc;
  logic wb_stb;
  logic wb_we;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_wdat;
  logic [31:0] wb_rdat;
  logic wb_ack;
  pief_pkg::pief_fwd_s fwd_req;
  pief_pkg::pief_fwd_s fwd_resp;
  pief_pkg::pief_mask_t exp_row [pief_pkg::NPORT];
  int error_cnt;
  int n_tests;

  pief_top DUT (.mclk(mclk), .resetn(resetn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .fwd_req(fwd_req), .fwd_resp(fwd_resp));
  pief_fwd_model fm (.mclk(mclk), .fwd_req(fwd_req), .fwd_resp(fwd_resp));

  initial begin
    mclk = 1'b0;
    forever begin
      #50 mclk = ~mclk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // The wait has no limit of its own; the watchdog ends a bus that never answers.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [31:0] q);
    @(posedge mclk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= d;
    wb_sel <= s;
    @(posedge mclk);
    while (wb_ack !== 1'b1) begin
      @(posedge mclk);
    end
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'h3, q);
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hf, q);
    check(q, exp, msg);
  endtask

  task automatic verify_all();
    pief_pkg::pief_fwd_s r;
    for (int p = 0; p < pief_pkg::NPORT; p++) begin
      rd_check(8'h40 + 8'(4 * p), {21'h0, exp_row[p]}, "row readback");
      fm.send(4'(p), 11'h7ff, r);
      check({16'h0, r.valid, r.src, r.dst}, {16'h0, 1'b1, 4'(p), exp_row[p]}, "filtered set");
    end
  endtask

  task automatic bulk(input int lo, input int hi, input pief_pkg::pief_op_e op, input pief_pkg::pief_mask_t stg);
    wr(pief_pkg::OFS_STAGE, {21'h0, stg});
    wr(pief_pkg::OFS_RANGE, 32'(hi) << 8 | 32'(lo));
    wr(pief_pkg::OFS_CMD, {30'h0, op});
    for (int p = lo; p <= hi; p++) begin
      exp_row[p] = (op == pief_pkg::PIEF_OP_LOAD) ? stg : (op == pief_pkg::PIEF_OP_SET_ALL) ? 11'h7ff : 11'h0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pief_pkg::pief_fwd_s r;
    logic [31:0] q;
    error_cnt = 0;
    n_tests = 0;
    resetn = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_wdat = 32'h0;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    for (int p = 0; p < pief_pkg::NPORT; p++) begin
      exp_row[p] = 11'h7ff;
    end
    verify_all();
    rd_check(pief_pkg::OFS_STAGE, 32'h7ff, "stage reset");
    rd_check(pief_pkg::OFS_RANGE, 32'h0a00, "range reset");
    rd_check(8'h6c, 32'h0, "unmapped read");
    $display("test reset_values done");
    for (int p = 0; p < pief_pkg::NPORT; p++) begin
      exp_row[p] = 11'h1 << ((p + 1) % 11);
      wr(8'h40 + 8'(4 * p), {21'h0, exp_row[p]});
    end
    verify_all();
    fm.send(4'h1, 11'h001, r);
    check({21'h0, r.dst}, 32'h0, "management port blocked");
    fm.send(4'h0, 11'h002, r);
    check({21'h0, r.dst}, 32'h002, "one-way permission");
    fm.send(4'hf, 11'h7ff, r);
    check({21'h0, r.dst}, 32'h0, "unknown source suppressed");
    wb(1'b1, 8'h5c, 32'h7ff, 4'h1, q);
    exp_row[7][7:0] = 8'hff;
    rd_check(8'h5c, {21'h0, exp_row[7]}, "low lane write");
    $display("test single_bits done");
    bulk(0, 10, pief_pkg::PIEF_OP_SET_ALL, 11'h0);
    verify_all();
    bulk(0, 10, pief_pkg::PIEF_OP_CLR_ALL, 11'h7ff);
    verify_all();
    bulk(2, 4, pief_pkg::PIEF_OP_LOAD, 11'h0f0);
    bulk(0, 0, pief_pkg::PIEF_OP_LOAD, 11'h401);
    verify_all();
    $display("test bulk_ops done");
    wr(8'h54, 32'h00f);
    fm.send(4'h5, 11'h7ff, r);
    check({21'h0, r.dst}, 32'h00f, "update seen at once");
    exp_row[5] = 11'h00f;
    wr(pief_pkg::OFS_CMD, 32'h0);
    wr(8'h6c, 32'h7ff);
    verify_all();
    rd_check(pief_pkg::OFS_CMD, 32'h0, "command reads zero");
    $display("test update_order done");
    end_of_test();
  end

  // Whole run needs about five hundred cycles; forty times that means a hang.
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    end_of_test();
  end
endmodule
